// File: rtl/atb_map.svh
// Register offsets, field positions and reset values of the timebase
`ifndef ATB_MAP_SVH
`define ATB_MAP_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define ATB_OFS_CTRL    8'h00
`define ATB_OFS_SLAVE   8'h04
`define ATB_OFS_CHAN    8'h08
`define ATB_OFS_STATUS  8'h0C
`define ATB_OFS_SWEVT   8'h10
`define ATB_OFS_COUNT   8'h14
`define ATB_OFS_DIV     8'h18
`define ATB_OFS_PERIOD  8'h1C

// ----------------------------------------------------------------------
// Field positions and codes
// ----------------------------------------------------------------------
`define ATB_STATUS_FLAG 0
`define ATB_STATUS_RUN  1
`define ATB_SWEVT_TRIG  0
`define ATB_SM_EXT_A    3'h7
`define ATB_SM_RESET    3'h4
`define ATB_MODE_EDGE   2'h0

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define ATB_RST_CTRL    7'h00
`define ATB_RST_SLAVE   16'h0000
`define ATB_RST_CHAN    10'h000
`define ATB_RST_WORD    16'h0000

`endif

// File: rtl/atb_pkg.sv
// Types shared by the advanced timer timebase
package atb_pkg;

	// Control register fields
	typedef struct packed {
		logic       pbuf;
		logic [1:0] mode;
		logic       dir;
		logic       ovf_src;
		logic       ovf_dis;
		logic       enable;
	} atb_ctrl_t;

	// Slave mode and outside input conditioning fields
	typedef struct packed {
		logic       ext_pol;
		logic       mode_b;
		logic [1:0] ext_div;
		logic [3:0] ext_flt;
		logic       rsv1;
		logic [2:0] trig_sel;
		logic       rsv0;
		logic [2:0] slave_mode_select;
	} atb_slave_t;

	// Channel input conditioning fields
	typedef struct packed {
		logic       ch2_pol;
		logic       ch1_pol;
		logic [3:0] ch2_flt;
		logic [3:0] ch1_flt;
	} atb_chan_t;

	// Current direction of the counter
	typedef enum logic {
		ATB_DIR_UP,
		ATB_DIR_DOWN
	} atb_dir_t;

endpackage

// File: rtl/atb_timebase.sv
// Clock selection, prescaler and counter timebase of an advanced timer
`timescale 1ns/1ps
// Function
// - Counter clock from internal clock, outside modes A/B, or trigger.
// - Internal clock is bus rate at factor one, else twice bus rate.
// - Slave mode 3'b111 selects mode A clocked by the chosen trigger.
// - Codes 4..7 pick ch1 both-edge, ch1, ch2, outside input.
// - Mode B enable clocks counter from the conditioned outside input.
// - Outside input gets polarity, two-bit divider and four-bit filter.
// - Channel sources get their four-bit filter and polarity bit.
// - Every outside or trigger input passes a synchroniser.
// - Codes 0..3 select internal triggers 0..3 in mode A.
// - Timer 1 takes 5,2,3,4; timer 8 takes 1,2,4,5.
// - 16-bit prescaler gives one count step every divider+1 ticks.
// - New divider value takes effect only at the next overflow event.
// - Period buffer off: period applies at once; on: at overflow event.
// - Counter reads live count; writes replace it immediately.
// - Overflow events on after reset; disable bit suppresses them.
// - Source bit clear: overflow, software trigger, slave reset raise it.
// - Run enable asserts one clock after the counter enable bit.
// - Two-bit count mode; direction bit picks up or down in mode 0.
// - Another timer's trigger output can clock this timer.
// - Mode 0 up: count 0 to period, wrap to 0, overflow event.
// - Mode 0 down: count period to 0, reload period, underflow event.
// - Counter holds while the active period is zero.
module atb_timebase #(
	parameter int TIMER_ID = 1
) (
	input  wire logic        CLK_IN,
	input  wire logic        ARST_N_IN,
	input  wire logic        WB_CYC_IN,
	input  wire logic        WB_STB_IN,
	input  wire logic        WB_WE_IN,
	input  wire logic [7:0]  WB_ADR_IN,
	input  wire logic [3:0]  WB_SEL_IN,
	input  wire logic [31:0] WB_DAT_IN,
	output logic      [31:0] WB_DAT_OUT,
	output logic             WB_ACK_OUT,
	input  wire logic        BUS_DIV1_IN,
	input  wire logic        CH1_IN,
	input  wire logic        CH2_IN,
	input  wire logic        EXT_IN,
	input  wire logic [8:1]  TRIGGER_OUTPUT_IN,
	output logic      [15:0] COUNT_OUT,
	output logic             OVERFLOW_OUT,
	output logic             OVF_FLAG_OUT,
	output logic             RUN_OUT
);

	`include "atb_map.svh"

	// ------------------------------------------------------------------
	// Elaboration check
	// ------------------------------------------------------------------
	if (TIMER_ID != 1 && TIMER_ID != 8) begin : g_bad_id
		$error("TIMER_ID must be 1 or 8");
	end

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	logic [1:0]          rst_sync;
	logic                rst_n;
	logic [7:0]          pin_meta;
	logic [7:0]          pin_s;
	logic [3:0]          flt_cnt [3];
	logic [2:0]          flt;
	logic [3:0]          flt_code [3];
	logic                ch1_d;
	logic                ch1_pp_d;
	logic                ch2_pp_d;
	logic                ext_p_d;
	logic [3:0]          is_d;
	logic [2:0]          ext_edges;
	logic                ext_tick;
	logic                half_ph;
	atb_pkg::atb_ctrl_t  ctrl;
	atb_pkg::atb_slave_t slv;
	atb_pkg::atb_chan_t  chn;
	atb_pkg::atb_dir_t   cdir;
	logic [15:0]         cnt;
	logic [15:0]         div_reg;
	logic [15:0]         div_act;
	logic [15:0]         pr_reg;
	logic [15:0]         pr_act;
	logic [15:0]         psc;
	logic                flag;
	logic                run;
	logic                ack;
	logic [31:0]         rdat;
	logic                uev_q;
	logic [15:0]         next_cnt;
	logic                hw_ovf;
	logic                next_down;

	// Merge a bus write into a 16-bit register under its byte enables
	function automatic logic [15:0] wmerge(input logic [15:0] old,
		input logic [31:0] dat, input logic [3:0] sel);
		wmerge = {sel[1] ? dat[15:8] : old[15:8],
			sel[0] ? dat[7:0] : old[7:0]};
	endfunction

	// ------------------------------------------------------------------
	// Reset release and input synchronisers
	// ------------------------------------------------------------------
	// Reset leaves through two flip-flops
	always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) rst_sync <= 2'h0;
		else rst_sync <= {rst_sync[0], 1'b1};
	end
	assign rst_n = rst_sync[1];

	// Internal triggers picked per instance from other timers
	wire [3:0] is_raw = (TIMER_ID == 8) ?
		{TRIGGER_OUTPUT_IN[5], TRIGGER_OUTPUT_IN[4], TRIGGER_OUTPUT_IN[2], TRIGGER_OUTPUT_IN[1]} :
		{TRIGGER_OUTPUT_IN[4], TRIGGER_OUTPUT_IN[3], TRIGGER_OUTPUT_IN[2], TRIGGER_OUTPUT_IN[5]};
	wire [7:0] pin_raw = {BUS_DIV1_IN, is_raw, EXT_IN, CH2_IN, CH1_IN};

	// Two-stage synchroniser on every outside input
	always_ff @(posedge CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			pin_meta <= 8'h00;
			pin_s    <= 8'h00;
		end else begin
			pin_meta <= pin_raw;
			pin_s    <= pin_meta;
		end
	end

	// ------------------------------------------------------------------
	// Input filters, polarity and outside divider
	// ------------------------------------------------------------------
	assign flt_code[0] = chn.ch1_flt;
	assign flt_code[1] = chn.ch2_flt;
	assign flt_code[2] = slv.ext_flt;

	// Level must differ for more than code cycles before it passes
	always_ff @(posedge CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			flt <= 3'h0;
			for (int i = 0; i < 3; i++) flt_cnt[i] <= 4'h0;
		end else begin
			for (int i = 0; i < 3; i++) begin
				if (pin_s[i] == flt[i]) begin
					flt_cnt[i] <= 4'h0;
				end else if (flt_cnt[i] >= flt_code[i]) begin
					flt[i]     <= pin_s[i];
					flt_cnt[i] <= 4'h0;
				end else begin
					flt_cnt[i] <= flt_cnt[i] + 4'h1;
				end
			end
		end
	end

	// Polarity applied after the filters
	wire ch1_pp = flt[0] ^ chn.ch1_pol;
	wire ch2_pp = flt[1] ^ chn.ch2_pol;
	wire ext_p  = flt[2] ^ slv.ext_pol;
	wire ext_rise = ext_p & ~ext_p_d;
	wire [2:0] ext_mask = 3'((4'h1 << slv.ext_div) - 4'h1);

	// Outside divider passes one of every 2^div rising edges
	always_ff @(posedge CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			ext_p_d   <= 1'b0;
			ext_edges <= 3'h0;
			ext_tick  <= 1'b0;
		end else begin
			ext_p_d  <= ext_p;
			ext_tick <= ext_rise && ((ext_edges & ext_mask) == 3'h0);
			if (ext_rise) ext_edges <= ext_edges + 3'h1;
		end
	end

	// Previous levels for edge detection
	always_ff @(posedge CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			ch1_d    <= 1'b0;
			ch1_pp_d <= 1'b0;
			ch2_pp_d <= 1'b0;
			is_d     <= 4'h0;
			half_ph  <= 1'b0;
		end else begin
			ch1_d    <= flt[0];
			ch1_pp_d <= ch1_pp;
			ch2_pp_d <= ch2_pp;
			is_d     <= pin_s[6:3];
			half_ph  <= ~half_ph;
		end
	end

	// ------------------------------------------------------------------
	// Clock source selection
	// ------------------------------------------------------------------
	// Edge pulses indexed by trigger source code
	wire [7:0] src_edges = {ext_tick,
		ch2_pp & ~ch2_pp_d, ch1_pp & ~ch1_pp_d, flt[0] ^ ch1_d,
		pin_s[6:3] & ~is_d};
	wire trig_edge = src_edges[slv.trig_sel];
	wire mode_a    = slv.slave_mode_select == `ATB_SM_EXT_A;
	wire int_tick  = pin_s[7] ? half_ph : 1'b1;
	wire tmr_tick  = slv.mode_b ? ext_tick :
		mode_a ? trig_edge : int_tick;
	wire slave_rst = slv.slave_mode_select == `ATB_SM_RESET && trig_edge;

	// ------------------------------------------------------------------
	// Register bus decode
	// ------------------------------------------------------------------
	wire req       = WB_CYC_IN & WB_STB_IN & ~ack;
	wire wr        = WB_CYC_IN & WB_STB_IN & WB_WE_IN & ack; // Ack edge
	wire wr_ctrl   = wr && WB_ADR_IN == `ATB_OFS_CTRL && WB_SEL_IN[0];
	wire wr_slave  = wr && WB_ADR_IN == `ATB_OFS_SLAVE;
	wire wr_chan   = wr && WB_ADR_IN == `ATB_OFS_CHAN;
	wire wr_status = wr && WB_ADR_IN == `ATB_OFS_STATUS && WB_SEL_IN[0];
	wire wr_swevt  = wr && WB_ADR_IN == `ATB_OFS_SWEVT && WB_SEL_IN[0];
	wire wr_cnt    = wr && WB_ADR_IN == `ATB_OFS_COUNT;
	wire wr_div    = wr && WB_ADR_IN == `ATB_OFS_DIV;
	wire wr_pr     = wr && WB_ADR_IN == `ATB_OFS_PERIOD;
	wire sw_trig   = wr_swevt & WB_DAT_IN[`ATB_SWEVT_TRIG];
	wire flag_clr  = wr_status & WB_DAT_IN[`ATB_STATUS_FLAG];
	wire [15:0] next_pr = wr_pr ? wmerge(pr_reg, WB_DAT_IN, WB_SEL_IN)
		: pr_reg;
	wire [15:0] slave_w = wmerge(slv, WB_DAT_IN, WB_SEL_IN);
	wire [15:0] chan_w  = wmerge({6'h00, chn}, WB_DAT_IN, WB_SEL_IN);
	wire edge_mode  = ctrl.mode == `ATB_MODE_EDGE;
	wire dir_shown  = edge_mode ? ctrl.dir : cdir == atb_pkg::ATB_DIR_DOWN;
	wire [31:0] rd_mux =
		WB_ADR_IN == `ATB_OFS_CTRL ? {25'h0, ctrl.pbuf, ctrl.mode,
			dir_shown, ctrl.ovf_src, ctrl.ovf_dis, ctrl.enable} :
		WB_ADR_IN == `ATB_OFS_SLAVE  ? {16'h0, slv} :
		WB_ADR_IN == `ATB_OFS_CHAN   ? {22'h0, chn} :
		WB_ADR_IN == `ATB_OFS_STATUS ? {30'h0, run, flag} :
		WB_ADR_IN == `ATB_OFS_COUNT  ? {16'h0, cnt} :
		WB_ADR_IN == `ATB_OFS_DIV    ? {16'h0, div_reg} :
		WB_ADR_IN == `ATB_OFS_PERIOD ? {16'h0, pr_reg} : 32'h0;

	// One-cycle acknowledge; unmapped offsets read zero
	always_ff @(posedge CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			ack  <= 1'b0;
			rdat <= 32'h0;
		end else begin
			ack <= req;
			if (req) rdat <= rd_mux;
		end
	end

	// Software-written configuration registers
	always_ff @(posedge CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			ctrl    <= `ATB_RST_CTRL;
			slv     <= `ATB_RST_SLAVE;
			chn     <= `ATB_RST_CHAN;
			div_reg <= `ATB_RST_WORD;
			pr_reg  <= `ATB_RST_WORD;
		end else begin
			if (wr_ctrl) ctrl <= WB_DAT_IN[6:0];
			if (wr_slave) slv <= slave_w;
			if (wr_chan) chn <= chan_w[9:0];
			if (wr_div) div_reg <= wmerge(div_reg, WB_DAT_IN, WB_SEL_IN);
			pr_reg <= next_pr;
		end
	end

	// ------------------------------------------------------------------
	// Prescaler, counter and overflow event
	// ------------------------------------------------------------------
	wire cnt_tick = run && tmr_tick && psc == div_act;
	wire cnt_step = cnt_tick && pr_act != 16'h0000;
	wire uev = ~ctrl.ovf_dis & (hw_ovf |
		(~ctrl.ovf_src & (sw_trig | slave_rst)));

	// Next count and wrap detection per counting mode
	always_comb begin
		next_cnt  = cnt;
		hw_ovf    = 1'b0;
		next_down = cdir == atb_pkg::ATB_DIR_DOWN;
		case ({edge_mode, ctrl.dir, cdir == atb_pkg::ATB_DIR_DOWN})
			3'b100, 3'b101: begin
				hw_ovf   = cnt_step && cnt >= pr_act;
				next_cnt = hw_ovf ? 16'h0000 : cnt + 16'h0001;
			end
			3'b110, 3'b111: begin
				hw_ovf   = cnt_step && cnt == 16'h0000;
				next_cnt = hw_ovf ? pr_act : cnt - 16'h0001;
			end
			3'b000, 3'b010: begin
				hw_ovf    = cnt_step && cnt >= pr_act - 16'h0001;
				next_cnt  = hw_ovf ? pr_act : cnt + 16'h0001;
				next_down = hw_ovf;
			end
			3'b001, 3'b011: begin
				hw_ovf    = cnt_step && cnt <= 16'h0001;
				next_cnt  = hw_ovf ? 16'h0000 : cnt - 16'h0001;
				next_down = ~hw_ovf;
			end
			default: begin
				next_cnt = cnt;
			end
		endcase
	end

	// Prescaler steps on each selected source tick
	always_ff @(posedge CLK_IN or negedge rst_n) begin
		if (!rst_n) psc <= 16'h0000;
		else if (uev) psc <= 16'h0000;
		else if (run && tmr_tick)
			psc <= (psc == div_act) ? 16'h0000 : psc + 16'h0001;
	end

	// Live counter; bus write wins over slave reset and counting
	always_ff @(posedge CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			cnt  <= 16'h0000;
			cdir <= atb_pkg::ATB_DIR_UP;
		end else if (wr_cnt) begin
			cnt <= wmerge(cnt, WB_DAT_IN, WB_SEL_IN);
		end else if (slave_rst) begin
			cnt  <= (edge_mode && ctrl.dir) ? pr_act : 16'h0000;
			cdir <= atb_pkg::ATB_DIR_UP;
		end else if (cnt_step) begin
			cnt  <= next_cnt;
			cdir <= next_down ? atb_pkg::ATB_DIR_DOWN : atb_pkg::ATB_DIR_UP;
		end
	end

	// Shadows, flag, run enable and event output
	always_ff @(posedge CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			div_act <= `ATB_RST_WORD;
			pr_act  <= `ATB_RST_WORD;
			flag    <= 1'b0;
			run     <= 1'b0;
			uev_q   <= 1'b0;
		end else begin
			if (uev) div_act <= div_reg;
			if (!ctrl.pbuf) pr_act <= next_pr;
			else if (uev) pr_act <= pr_reg;
			flag  <= uev | (flag & ~flag_clr);
			run   <= ctrl.enable;
			uev_q <= uev;
		end
	end

	assign WB_ACK_OUT   = ack;
	assign WB_DAT_OUT   = rdat;
	assign COUNT_OUT    = cnt;
	assign OVERFLOW_OUT = uev_q;
	assign OVF_FLAG_OUT = flag;
	assign RUN_OUT      = run;

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (!rst_n);

	chk_run_delay: assert property ($rose(ctrl.enable) |-> !run ##1 run)
		else $error("run enable not one cycle after enable bit");
	chk_flag_set: assert property (uev |=> flag && OVERFLOW_OUT)
		else $error("overflow flag or event output missing");
	chk_flag_hold: assert property (flag && !flag_clr |=> flag)
		else $error("overflow flag dropped without clear");
	chk_ovf_off: assert property (ctrl.ovf_dis |-> !uev)
		else $error("overflow event while disabled");
	chk_src_only: assert property (ctrl.ovf_src && !hw_ovf |-> !uev)
		else $error("overflow event from non-counter source");
	chk_sw_event: assert property (sw_trig && !ctrl.ovf_src &&
		!ctrl.ovf_dis |=> OVERFLOW_OUT)
		else $error("software trigger raised no event");
	chk_up_wrap: assert property (cnt_step && edge_mode && !ctrl.dir &&
		cnt == pr_act && !wr_cnt && !slave_rst && !ctrl.ovf_dis
		|=> cnt == 16'h0000 && OVERFLOW_OUT)
		else $error("up counter did not wrap at period");
	chk_down_load: assert property (cnt_step && edge_mode && ctrl.dir &&
		cnt == 16'h0000 && !wr_cnt && !slave_rst |=> cnt == $past(pr_act))
		else $error("down counter did not reload period");
	chk_zero_hold: assert property (pr_act == 16'h0000 && !wr_cnt &&
		!slave_rst |=> $stable(cnt))
		else $error("counter moved with zero period");
	chk_div_hold: assert property (!uev |=> $stable(div_act))
		else $error("divider changed outside overflow event");
	chk_pr_buffer: assert property (ctrl.pbuf && !uev |=> $stable(pr_act))
		else $error("buffered period changed outside event");
	chk_cnt_write: assert property (wr_cnt && WB_SEL_IN[1:0] == 2'h3
		|=> cnt == $past(WB_DAT_IN[15:0]))
		else $error("counter write not applied");
	chk_psc_step: assert property (run && tmr_tick && psc != div_act &&
		!uev |=> psc == $past(psc) + 16'h0001)
		else $error("prescaler did not step");

	cov_up_wrap: cover property (hw_ovf && edge_mode && !ctrl.dir);
	cov_down_wrap: cover property (hw_ovf && edge_mode && ctrl.dir);
	cov_mode_b: cover property (slv.mode_b && ext_tick && cnt_tick);
	cov_slave_rst: cover property (slave_rst ##1 OVERFLOW_OUT);

endmodule

// File: bench/atb_pulse_src.sv
// Pulse source standing in for another timer's trigger output or a pin
`timescale 1ns/1ps
module atb_pulse_src (
	input  wire logic       clk_in,
	input  wire logic       go_in,
	input  wire logic [7:0] num_in,
	input  wire logic [7:0] wid_in,
	output logic            pulse_out,
	output logic            busy_out
);
	int left = 0;
	int tmr  = 0;

	// Busy while edges remain
	assign busy_out = (left != 0);

	// Toggle every wid_in cycles, num_in whole pulses, then idle low
	always @(posedge clk_in) begin
		if (left == 0) begin
			pulse_out <= 1'b0;
			if (go_in) begin
				left <= 2 * num_in;
				tmr  <= wid_in;
			end
		end else if (tmr > 1) begin
			tmr <= tmr - 1;
		end else begin
			pulse_out <= ~pulse_out;
			left      <= left - 1;
			tmr       <= wid_in;
		end
	end
endmodule

// File: bench/tb_atb_timebase.sv
// Self-checking bench of the advanced timer timebase
`timescale 1ns/1ps
`include "atb_map.svh"
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin \
	n_fail++; $display("unexpected %s exp %0h got %0h", nm, e, g); end end
module tb_atb_timebase;
	logic        clk      = 1'b0;
	logic        arst_n   = 1'b0;
	logic        cyc      = 1'b0;
	logic        stb      = 1'b0;
	logic        we       = 1'b0;
	logic [7:0]  adr      = 8'h00;
	logic [31:0] wdat     = 32'h0000_0000;
	logic [31:0] rdat;
	logic        ack;
	logic        div1     = 1'b0;
	logic        go       = 1'b0;
	logic [7:0]  num      = 8'h00;
	logic [7:0]  wid      = 8'h08;
	logic [2:0]  src      = 3'h0;
	logic        noise    = 1'b0;
	logic        pls;
	logic        busy;
	logic [8:1]  trg;
	logic [15:0] cnt;
	logic        ovf;
	logic        flag;
	logic        run;
	logic        run_q    = 1'b0;
	logic [31:0] rd;
	int          n_fail   = 0;
	int          compares = 0;
	int          cycles   = 0;
	int          n_ovf    = 0;
	int          t_ack    = 0;
	int          t_run    = 0;
	int          seed;

	// ----------------------------------------------------------------
	// Clock, pins and design
	// ----------------------------------------------------------------
	initial begin
		forever #5 clk = ~clk;
	end

	// Selected pin gets the pulses, every other pin sees noise
	assign trg[8:6] = {3{noise}};
	assign trg[5]   = (src == 3'h0) ? pls : noise;
	assign trg[4]   = (src == 3'h3) ? pls : noise;
	assign trg[3]   = (src == 3'h2) ? pls : noise;
	assign trg[2]   = (src == 3'h1) ? pls : noise;
	assign trg[1]   = noise;

	atb_timebase #(.TIMER_ID(1)) i_atb_timebase (
		.CLK_IN(clk), .ARST_N_IN(arst_n), .WB_CYC_IN(cyc),
		.WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr),
		.WB_SEL_IN(4'hF), .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat),
		.WB_ACK_OUT(ack), .BUS_DIV1_IN(div1),
		.CH1_IN((src == 3'h4 || src == 3'h5) ? pls : noise),
		.CH2_IN((src == 3'h6) ? pls : noise),
		.EXT_IN((src == 3'h7) ? pls : noise), .TRIGGER_OUTPUT_IN(trg),
		.COUNT_OUT(cnt), .OVERFLOW_OUT(ovf), .OVF_FLAG_OUT(flag),
		.RUN_OUT(run)
	);

	atb_pulse_src i_atb_pulse_src (
		.clk_in(clk), .go_in(go), .num_in(num), .wid_in(wid),
		.pulse_out(pls), .busy_out(busy)
	);

	// Cycle count, timeout, noise, event and enable timing
	always @(posedge clk) begin
		cycles++;
		run_q <= run;
		if (cycles % 5 == 0) noise <= ~noise;
		if (ovf === 1'b1) n_ovf++;
		if (ack === 1'b1) t_ack = cycles;
		if (run === 1'b1 && run_q === 1'b0) t_run = cycles;
		if (cycles == 40000) begin
			n_fail++;
			end_sim();
		end
	end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic end_sim();
		if (n_fail == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Classic single Wishbone cycle, one idle cycle after
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [15:0] d);
		cyc  <= 1'b1;
		stb  <= 1'b1;
		we   <= w;
		adr  <= a;
		wdat <= {16'h0000, d};
		@(posedge clk);
		while (ack !== 1'b1) @(posedge clk);
		rd = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we  <= 1'b0;
		@(posedge clk);
	endtask

	// Model of count and event; when counting up, period p1 holds after the first wrap
	task automatic tb_run(input int p0, input int p1, input int step,
		input bit dn, input int n);
		int m;
		int ph;
		int t;
		bit w;
		m  = dn ? p0 : 0;
		ph = step;
		t  = 0;
		w  = 1'b0;
		@(negedge clk);
		while (cnt === m[15:0] && t < 300) begin
			@(negedge clk);
			t++;
		end
		for (int i = 0; i < n; i++) begin
			w = 1'b0;
			if (ph == step) begin
				ph = 0;
				if (!dn && m == p0) begin
					m  = 0;
					w  = 1'b1;
					p0 = p1;
				end else if (dn && m == 0) begin
					m = p0;
					w = 1'b1;
				end else begin
					m = dn ? m - 1 : m + 1;
				end
			end
			ph++;
			`CHK("count", m[15:0], cnt)
			`CHK("overflow", w, ovf)
			@(negedge clk);
		end
		@(posedge clk);
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		int tc;
		int ex;
		int p;
		int q;
		int d;
		int k;
		logic [3:0] ef;
		seed = $urandom(32'h5e50);
		repeat (16) @(posedge clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk);
		// Reset values and an unmapped word
		for (int a = 0; a <= 32; a += 4) begin
			wb(1'b0, a[7:0], 16'h0000);
			`CHK("reset", 32'h0000_0000, rd)
		end
		wb(1'b1, 8'h20, 16'hFFFF);
		wb(1'b0, 8'h20, 16'h0000);
		`CHK("unmapped", 32'h0000_0000, rd)
		wb(1'b1, `ATB_OFS_CTRL, 16'h0001);
		repeat (3) @(posedge clk);
		`CHK("run delay", 1, t_run - t_ack - 1)
		// Outside clock modes, every trigger code, divider and filter
		for (int i = 0; i < 12; i++) begin
			tc = (i < 8) ? i : ((i == 11) ? 6 : 7);
			ex = (i == 9) ? 4 : 2 + $urandom % 4;
			ef = (i == 10) ? 4'hF : 4'h0;
			src <= tc[2:0];
			wb(1'b1, `ATB_OFS_CTRL, 16'h0000);
			wb(1'b1, `ATB_OFS_CHAN, {6'h00, 1'b0, 1'($urandom),
				(i == 11) ? 4'hF : 4'h0, 4'h0});
			wb(1'b1, `ATB_OFS_SLAVE, {(i == 8) ? 1'($urandom) : 1'b0,
				i == 8, (i == 9) ? 2'h1 : 2'h0, ef, 1'b0, tc[2:0],
				1'b0, (i == 8) ? 3'h0 : `ATB_SM_EXT_A});
			wb(1'b1, `ATB_OFS_PERIOD, 16'hFFFF);
			wb(1'b1, `ATB_OFS_CTRL, 16'h0001);
			repeat (30) @(posedge clk);
			wb(1'b1, `ATB_OFS_COUNT, 16'h0000);
			wid <= (i >= 10) ? 8'h04 : 8'(5 + $urandom % 5);
			num <= ex[7:0];
			go  <= 1'b1;
			@(posedge clk);
			go <= 1'b0;
			repeat (2) @(posedge clk);
			while (busy === 1'b1) @(posedge clk);
			repeat (20) @(posedge clk);
			ex = (i >= 10) ? 0 : (i == 9) ? 2 : (tc == 4) ? 2 * ex : ex;
			wb(1'b0, `ATB_OFS_COUNT, 16'h0000);
			`CHK("edges", ex[15:0], rd[15:0])
		end
		// Internal clock up count
		p = 3 + $urandom % 10;
		d = 1 + $urandom % 3;
		wb(1'b1, `ATB_OFS_CTRL, 16'h0000);
		wb(1'b1, `ATB_OFS_SLAVE, 16'h0000);
		wb(1'b1, `ATB_OFS_PERIOD, p[15:0]);
		wb(1'b1, `ATB_OFS_COUNT, 16'h0000);
		wb(1'b1, `ATB_OFS_CTRL, 16'h0001);
		tb_run(p, p, 1, 1'b0, 3 * (p + 1) + 2);
		`CHK("flag", 1'b1, flag)
		wb(1'b1, `ATB_OFS_CTRL, 16'h0000);
		repeat (5) @(posedge clk);
		`CHK("flag held", 1'b1, flag)
		wb(1'b1, `ATB_OFS_STATUS, 16'h0001);
		wb(1'b0, `ATB_OFS_STATUS, 16'h0000);
		`CHK("flag clear", 32'h0000_0000, rd)
		// New divider waits for an event
		wb(1'b1, `ATB_OFS_DIV, d[15:0]);
		wb(1'b1, `ATB_OFS_PERIOD, 16'hFFFF);
		wb(1'b1, `ATB_OFS_COUNT, 16'h0000);
		wb(1'b1, `ATB_OFS_CTRL, 16'h0001);
		tb_run(65535, 65535, 1, 1'b0, 8);
		// Software event under disable, source bit and plain setting
		for (int j = 0; j < 3; j++) begin
			wb(1'b1, `ATB_OFS_CTRL, (j == 0) ? 16'h2 : (j == 1) ? 16'h4 : 16'h0);
			wb(1'b1, `ATB_OFS_STATUS, 16'h0001);
			k = n_ovf;
			wb(1'b1, `ATB_OFS_SWEVT, 16'h0001);
			repeat (3) @(posedge clk);
			`CHK("sw event", j == 2, n_ovf - k)
			`CHK("sw flag", j == 2, flag)
		end
		// Divided up, down, then half-rate timer clock
		wb(1'b1, `ATB_OFS_PERIOD, p[15:0]);
		wb(1'b1, `ATB_OFS_COUNT, 16'h0000);
		wb(1'b1, `ATB_OFS_CTRL, 16'h0001);
		tb_run(p, p, d + 1, 1'b0, 2 * (p + 1) * (d + 1) + 4);
		wb(1'b1, `ATB_OFS_CTRL, 16'h0000);
		wb(1'b1, `ATB_OFS_COUNT, p[15:0]);
		wb(1'b1, `ATB_OFS_CTRL, 16'h0009);
		tb_run(p, p, d + 1, 1'b1, 2 * (p + 1) * (d + 1) + 4);
		wb(1'b1, `ATB_OFS_CTRL, 16'h0000);
		div1 <= 1'b1;
		wb(1'b1, `ATB_OFS_COUNT, 16'h0000);
		wb(1'b1, `ATB_OFS_CTRL, 16'h0001);
		tb_run(p, p, 2 * (d + 1), 1'b0, 4 * (p + 1) * (d + 1) + 4);
		// Buffered period applies at the wrap
		q = 3 + $urandom % 10;
		div1 <= 1'b0;
		wb(1'b1, `ATB_OFS_CTRL, 16'h0000);
		wb(1'b1, `ATB_OFS_DIV, 16'h0000);
		wb(1'b1, `ATB_OFS_SWEVT, 16'h0001);
		wb(1'b1, `ATB_OFS_CTRL, 16'h0040);
		wb(1'b1, `ATB_OFS_PERIOD, q[15:0]);
		wb(1'b1, `ATB_OFS_COUNT, 16'h0000);
		wb(1'b1, `ATB_OFS_CTRL, 16'h0041);
		tb_run(p, q, 1, 1'b0, p + 2 * q + 4);
		// Slave reset mode clears the count and raises an event
		src <= 3'h0;
		wb(1'b1, `ATB_OFS_CTRL, 16'h0000);
		wb(1'b1, `ATB_OFS_SLAVE, {9'h000, 3'h0, 1'b0, `ATB_SM_RESET});
		wb(1'b1, `ATB_OFS_COUNT, 16'h1234);
		k = n_ovf;
		num <= 8'h01;
		go  <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		repeat (2) @(posedge clk);
		while (busy === 1'b1) @(posedge clk);
		repeat (20) @(posedge clk);
		`CHK("slave event", 1, n_ovf - k)
		wb(1'b0, `ATB_OFS_COUNT, 16'h0000);
		`CHK("slave reset", 16'h0000, rd[15:0])
		// Counter write and read, then a zero period stalls
		ex = $urandom % 65536;
		wb(1'b1, `ATB_OFS_CTRL, 16'h0000);
		wb(1'b1, `ATB_OFS_COUNT, ex[15:0]);
		wb(1'b0, `ATB_OFS_COUNT, 16'h0000);
		`CHK("count rw", ex[15:0], rd[15:0])
		wb(1'b1, `ATB_OFS_PERIOD, 16'h0000);
		wb(1'b1, `ATB_OFS_COUNT, 16'h0005);
		wb(1'b1, `ATB_OFS_CTRL, 16'h0001);
		repeat (20) @(posedge clk);
		`CHK("stalled", 16'h0005, cnt)
		end_sim();
	end
endmodule
